// ---- src/pgsm_device.sv ----
/*
 Device end: global state machine of the power controller with input
 deglitch, enable window, sleep delay, reset hold and long-press timers.
 Assumes asynchronous pins from the host and supply monitors; faults
 are level inputs already filtered upstream.
*/
`timescale 1ns/1ps
module pgsm_device #(
  parameter int PB_DG = pgsm_pkg::PB_DG_CYC,
  parameter int EN_DG = pgsm_pkg::EN_DG_CYC,
  parameter int RST_DG = pgsm_pkg::RST_DG_CYC,
  parameter int EN_WIN = pgsm_pkg::EN_WIN_CYC,
  parameter int SLEEP_DLY = pgsm_pkg::SLEEP_DLY_CYC,
  parameter int RESET_MIN = pgsm_pkg::RESET_MIN_CYC,
  parameter int LONG_PRESS = pgsm_pkg::LONG_PRESS_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  pgsm_if.device link,
  input wire logic pushbutton_in,
  input wire logic usb_supply_in,
  input wire logic ac_supply_in,
  input wire logic fault_in,
  input wire logic off_select_in,
  input wire logic always_on_was_on_in,
  input wire logic [pgsm_pkg::RAIL_W-1:0] unseq_rails_in,
  input wire logic seq_done_in,
  output pgsm_pkg::pgsm_state_t state_out,
  output logic [pgsm_pkg::RAIL_W-1:0] unseq_rails_out,
  output logic always_on_regulator_out,
  output logic seq_up_out,
  output logic seq_down_out,
  output logic regs_clear_out,
  output logic serial_enable_out,
  output logic charger_enable_out
);
  import pgsm_pkg::*;
  pgsm_state_t state;
  logic [4:0] s1;
  logic [4:0] s2;
  logic pb_f, en_f, rst_f;
  logic usb_d, ac_d, pb_d;
  logic wake_ev, long_press;
  logic [CNT_W-1:0] pb_dc, en_dc, rst_dc, tmr, hold;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      // idle pin levels: button up, enable low, reset high, no supply
      s1 <= 5'h14;
      s2 <= 5'h14;
    end else begin
      s1 <= {pushbutton_in, link.power_enable, link.hard_reset_n,
             usb_supply_in, ac_supply_in};
      s2 <= s1;
    end
  end

  // ****************************************
  // deglitch filters
  // ****************************************
  function automatic logic [CNT_W-1:0] dg_next(input logic raw,
      input logic filt, input logic [CNT_W-1:0] cnt);
    dg_next = (raw == filt) ? '0 : cnt + 1'b1;
  endfunction

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pb_f <= 1'b1;
      pb_dc <= '0;
    end else begin
      pb_dc <= dg_next(s2[4], pb_f, pb_dc);
      if (s2[4] != pb_f && pb_dc >= CNT_W'(PB_DG - 1)) begin
        pb_f <= s2[4];
        pb_dc <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      en_f <= 1'b0;
      en_dc <= '0;
    end else begin
      en_dc <= dg_next(s2[3], en_f, en_dc);
      if (s2[3] != en_f && en_dc >= CNT_W'(EN_DG - 1)) begin
        en_f <= s2[3];
        en_dc <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rst_f <= 1'b1;
      rst_dc <= '0;
    end else begin
      rst_dc <= dg_next(s2[2], rst_f, rst_dc);
      if (s2[2] != rst_f && rst_dc >= CNT_W'(RST_DG - 1)) begin
        rst_f <= s2[2];
        rst_dc <= '0;
      end
    end
  end

  // ****************************************
  // wake events and long press
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      usb_d <= 1'b0;
      ac_d <= 1'b0;
      pb_d <= 1'b1;
    end else begin
      usb_d <= s2[1];
      ac_d <= s2[0];
      pb_d <= pb_f;
    end
  end
  assign wake_ev = (pb_d && !pb_f) || (s2[1] && !usb_d) || (s2[0] && !ac_d);

  // press counter restarts on button release and after each long press
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      hold <= '0;
    end else if (pb_f || long_press) begin
      hold <= '0;
    end else begin
      hold <= hold + 1'b1;
    end
  end
  assign long_press = !pb_f && hold >= CNT_W'(LONG_PRESS - 1);

  // ****************************************
  // state machine
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state <= PGSM_OFF;
      tmr <= '0;
    end else begin
      tmr <= tmr + 1'b1;
      if (fault_in && state != PGSM_OFF) begin
        state <= PGSM_OFF;
        tmr <= '0;
      end else if ((!rst_f || long_press) && state != PGSM_OFF &&
                   state != PGSM_RESET) begin
        state <= PGSM_RESET;
        tmr <= '0;
      end else begin
        unique case (state)
          PGSM_OFF: if (wake_ev && !fault_in) begin
            state <= PGSM_WAKE;
            tmr <= '0;
          end
          PGSM_WAKE: if (en_f) begin
            state <= PGSM_ACTIVE;
            tmr <= '0;
          end else if (tmr >= CNT_W'(EN_WIN - 1)) begin
            state <= PGSM_OFF;
            tmr <= '0;
          end
          PGSM_ACTIVE: if (!en_f) begin
            tmr <= '0;
            if (off_select_in) state <= PGSM_OFF;
            else state <= PGSM_PWRDN;
          end
          PGSM_PWRDN: if (tmr >= CNT_W'(SLEEP_DLY - 1)) begin
            state <= PGSM_SLEEP;
            tmr <= '0;
          end
          PGSM_SLEEP: if (wake_ev || en_f) begin
            state <= en_f ? PGSM_ACTIVE : PGSM_WAKE;
            tmr <= '0;
          end
          PGSM_RESET: if (rst_f && tmr >= CNT_W'(RESET_MIN - 1)) begin
            state <= PGSM_WAKE;
            tmr <= '0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_out <= PGSM_OFF;
      unseq_rails_out <= RAIL_RESET;
      always_on_regulator_out <= 1'b0;
      seq_up_out <= 1'b0;
      seq_down_out <= 1'b0;
      regs_clear_out <= 1'b1;
      serial_enable_out <= 1'b0;
      charger_enable_out <= 1'b0;
      link.wake_notify_oe <= 1'b0;
      link.wake_notify_o <= 1'b0;
    end else begin
      state_out <= state;
      unique case (state)
        PGSM_OFF, PGSM_RESET: unseq_rails_out <= RAIL_RESET;
        PGSM_WAKE: unseq_rails_out <= unseq_rails_in;
        default: unseq_rails_out <= unseq_rails_out;
      endcase
      if (state == PGSM_OFF) always_on_regulator_out <= 1'b0;
      else if (state == PGSM_WAKE) always_on_regulator_out <= 1'b1;
      else if (state == PGSM_SLEEP || state == PGSM_PWRDN)
        always_on_regulator_out <= always_on_was_on_in;
      else if (state == PGSM_RESET) always_on_regulator_out <= 1'b0;
      seq_up_out <= state == PGSM_ACTIVE && state_out != PGSM_ACTIVE;
      seq_down_out <= (state == PGSM_PWRDN || state == PGSM_RESET ||
                       state == PGSM_OFF) && !seq_done_in;
      regs_clear_out <= (state == PGSM_OFF || state == PGSM_SLEEP ||
                         state == PGSM_RESET) && state_out != state;
      serial_enable_out <= state != PGSM_OFF;
      charger_enable_out <= state != PGSM_OFF &&
                            (s2[1] || s2[0]);
      link.wake_notify_o <= 1'b0;
      // no notify while a hard reset is pending
      link.wake_notify_oe <= state == PGSM_WAKE && !en_f &&
                             rst_f;
    end
  end
endmodule

// ---- src/pgsm_pkg.sv ----
/*
 Package of the global power state controller: states, timing constants
 and the sizes shared by the device end and the host end.
 Assumes a single 100 MHz clock on both ends.
*/
package pgsm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int PB_DG_MS = 50;
  localparam int EN_DG_MS = 50;
  localparam int RST_DG_MS = 30;
  localparam int EN_WIN_S = 5;
  localparam int SLEEP_DLY_S = 1;
  localparam int RESET_MIN_S = 1;
  localparam int LONG_PRESS_S = 8;
  localparam int PB_DG_CYC = PB_DG_MS * (CLK_HZ / 1000);
  localparam int EN_DG_CYC = EN_DG_MS * (CLK_HZ / 1000);
  localparam int RST_DG_CYC = RST_DG_MS * (CLK_HZ / 1000);
  localparam int EN_WIN_CYC = EN_WIN_S * CLK_HZ;
  localparam int SLEEP_DLY_CYC = SLEEP_DLY_S * CLK_HZ;
  localparam int RESET_MIN_CYC = RESET_MIN_S * CLK_HZ;
  localparam int LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
  localparam int CNT_W = 32;
  localparam int RAIL_W = 8;
  localparam logic [RAIL_W-1:0] RAIL_RESET = 8'h00;
  typedef enum logic [2:0] {
    PGSM_OFF, PGSM_WAKE, PGSM_ACTIVE, PGSM_PWRDN, PGSM_SLEEP, PGSM_RESET
  } pgsm_state_t;
endpackage

// ---- src/pgsm_if.sv ----
/*
 Link between the power controller and the host processor.
 Assumes both ends share ref_clk_in; wake notify is open drain,
 the wire level is resolved here from the enable.
*/
`timescale 1ns/1ps
interface pgsm_if;
  logic power_enable;
  logic hard_reset_n;
  logic wake_notify_oe;
  logic wake_notify_o;
  logic wake_notify_n;
  // open-drain wire with pull-up
  assign wake_notify_n = wake_notify_oe ? wake_notify_o : 1'b1;
  modport device (input power_enable, input hard_reset_n,
    output wake_notify_oe, output wake_notify_o);
  modport host (output power_enable, output hard_reset_n,
    input wake_notify_n);
endinterface

// ---- src/pgsm_host.sv ----
/*
 Host end: drives power enable and hard reset from user commands and
 reports wake notifications.
 Assumes the device end sits on the other side of pgsm_if.
*/
`timescale 1ns/1ps
module pgsm_host (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  pgsm_if.host link,
  input wire logic power_enable_in,
  input wire logic hard_reset_req_in,
  output logic wake_seen_out
);
  import pgsm_pkg::*;
  logic wk_s1;
  logic wk_s2;
  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      link.power_enable <= 1'b0;
      link.hard_reset_n <= 1'b1;
    end else begin
      link.power_enable <= power_enable_in;
      link.hard_reset_n <= !hard_reset_req_in;
    end
  end
  // ****************************************
  // wake notify sampling
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      wk_s1 <= 1'b1;
      wk_s2 <= 1'b1;
      wake_seen_out <= 1'b0;
    end else begin
      wk_s1 <= link.wake_notify_n;
      wk_s2 <= wk_s1;
      wake_seen_out <= !wk_s2;
    end
  end
endmodule

// ---- testbench/pgsm_assertions.sv ----
/* checker on the signals of the power controller link
   assumes one clock and a synchronous active-low reset */
`timescale 1ns/1ps
module pgsm_assertions #(
  parameter int RST_DG = 3,
  parameter int EN_DG = 4,
  parameter int EN_WIN = 100
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic power_enable,
  input wire logic hard_reset_n,
  input wire logic wake_notify_oe,
  input wire logic wake_notify_o,
  input wire logic wake_notify_n
);
  int en_cnt;
  int oe_cnt;
  // consecutive cycles of enable high and notify driven
  always_ff @(posedge ref_clk_in) begin
    en_cnt <= (nrst_in && power_enable) ? en_cnt + 1 : 0;
  end
  always_ff @(posedge ref_clk_in) begin
    oe_cnt <= (nrst_in && wake_notify_oe) ? oe_cnt + 1 : 0;
  end
  property p_drive_low;
    @(posedge ref_clk_in) disable iff (!nrst_in)
    wake_notify_oe |-> !wake_notify_o && !wake_notify_n;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("notify driven but wire not low");
  property p_release;
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (en_cnt > EN_DG + 4) |-> (oe_cnt < 4);
  endproperty
  a_release: assert property (p_release)
    else $error("notify held after enable asserted");
  property p_window;
    @(posedge ref_clk_in) disable iff (!nrst_in)
    oe_cnt <= EN_WIN + 4;
  endproperty
  a_window: assert property (p_window)
    else $error("notify outlasted enable window");
  property p_idle;
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !wake_notify_oe |-> wake_notify_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("released notify not high");
  property p_reset;
    @(posedge ref_clk_in)
    !nrst_in |=> !wake_notify_oe && hard_reset_n && !power_enable;
  endproperty
  a_reset: assert property (p_reset)
    else $error("link pins wrong in reset");
  int rst_cnt;
  // consecutive cycles of hard reset held low
  always_ff @(posedge ref_clk_in) begin
    rst_cnt <= (nrst_in && !hard_reset_n) ? rst_cnt + 1 : 0;
  end
  property p_reset_quiet;
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (rst_cnt > RST_DG + 4) |-> !wake_notify_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("notify driven while hard reset held");
endmodule

// ---- testbench/pmic_global_state_machine_tb.sv ----
/* self-checking bench: host and device ends joined by pgsm_if
   assumes short timing parameters for simulation */
`timescale 1ns/1ps
module pmic_global_state_machine_tb;
  import pgsm_pkg::*;
  localparam int PD = 4, ED = 4, RD = 3, EW = 100, SD = 20, RM = 20, LP = 50;
  logic ref_clk_in, nrst_in, pb, usb, ac, flt, osel, pe, hrq, aon, sdone;
  logic [7:0] rails, rails_o;
  logic ao, seen, sdn, ser, chg, sup, clr;
  pgsm_state_t st;
  int bad_count, checks_done, n;
  int su_cnt, rc_cnt, su0, rc0;
  logic [31:0] r;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; $display("FAIL %0t got %h want %h", $time, a, b); end end
  pgsm_if pgsm_if_i();
  pgsm_host pgsm_host_i(.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .link(pgsm_if_i), .power_enable_in(pe), .hard_reset_req_in(hrq),
    .wake_seen_out(seen));
  pgsm_device #(.PB_DG(PD), .EN_DG(ED), .RST_DG(RD), .EN_WIN(EW),
    .SLEEP_DLY(SD), .RESET_MIN(RM), .LONG_PRESS(LP)) pgsm_device_i(
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .link(pgsm_if_i),
    .pushbutton_in(pb), .usb_supply_in(usb), .ac_supply_in(ac),
    .fault_in(flt), .off_select_in(osel), .always_on_was_on_in(aon),
    .unseq_rails_in(rails), .seq_done_in(sdone), .state_out(st),
    .unseq_rails_out(rails_o), .always_on_regulator_out(ao),
    .seq_up_out(sup), .seq_down_out(sdn), .regs_clear_out(clr),
    .serial_enable_out(ser), .charger_enable_out(chg));
  pgsm_assertions #(.RST_DG(RD), .EN_DG(ED), .EN_WIN(EW)) pgsm_assertions_i(
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .power_enable(pgsm_if_i.power_enable),
    .hard_reset_n(pgsm_if_i.hard_reset_n),
    .wake_notify_oe(pgsm_if_i.wake_notify_oe),
    .wake_notify_o(pgsm_if_i.wake_notify_o),
    .wake_notify_n(pgsm_if_i.wake_notify_n));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // unsequenced rails expected at the outputs
  function automatic logic [7:0] exp_rails(pgsm_state_t s, logic [7:0] m);
    return (s == PGSM_OFF || s == PGSM_RESET) ? 8'h00 : m;
  endfunction
  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  task automatic wst(pgsm_state_t s, int mx);
    n = 0;
    while (st !== s && n < mx) begin
      @(negedge ref_clk_in);
      n++;
    end
    `CHK(n < mx, 1'b1)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // pulse catchers for one-cycle outputs
  always @(posedge ref_clk_in) begin
    if (sup === 1'b1) su_cnt++;
    if (clr === 1'b1) rc_cnt++;
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    {nrst_in, usb, ac, flt, osel, pe, hrq, sdone} = '0;
    pb = 1'b1;
    aon = 1'b1;
    r = 32'h7378;
    rails = r[7:0];
    bad_count = 0;
    checks_done = 0;
    cyc(6);
    `CHK(st, PGSM_OFF)
    `CHK(clr, 1'b1)
    `CHK(ser, 1'b0)
    nrst_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      pb = 1'b0;
      cyc(r % 3 + 1);
      pb = 1'b1;
      cyc(8);
      `CHK(st, PGSM_OFF)
    end
    pe = 1'b1;
    cyc(20);
    `CHK(st, PGSM_OFF)
    pe = 1'b0;
    rails = r[15:8];
    cyc(10);
    usb = 1'b1;
    wst(PGSM_WAKE, 20);
    cyc(4);
    `CHK(pgsm_if_i.wake_notify_n, 1'b0)
    `CHK(seen, 1'b1)
    `CHK(rails_o, exp_rails(PGSM_WAKE, rails))
    wst(PGSM_OFF, EW + 10);
    `CHK(n >= EW - 8, 1'b1)
    pb = 1'b0;
    wst(PGSM_WAKE, 20);
    `CHK(n >= PD, 1'b1)
    pb = 1'b1;
    su0 = su_cnt;
    pe = 1'b1;
    wst(PGSM_ACTIVE, 20);
    `CHK(n >= ED, 1'b1)
    cyc(3);
    `CHK(su_cnt, su0 + 1)
    `CHK(pgsm_if_i.wake_notify_n, 1'b1)
    rc0 = rc_cnt;
    pe = 1'b0;
    wst(PGSM_PWRDN, 20);
    `CHK(sdn, 1'b1)
    sdone = 1'b1;
    wst(PGSM_SLEEP, SD + 10);
    `CHK(n >= SD - 3, 1'b1)
    cyc(3);
    `CHK(rc_cnt, rc0 + 1)
    `CHK(ao, 1'b1)
    `CHK(rails_o, rails)
    `CHK(chg, 1'b1)
    pe = 1'b1;
    wst(PGSM_ACTIVE, 20);
    aon = 1'b0;
    pe = 1'b0;
    wst(PGSM_SLEEP, SD + 40);
    `CHK(ao, 1'b0)
    aon = 1'b1;
    pe = 1'b1;
    wst(PGSM_ACTIVE, 20); // again from sleep
    osel = 1'b1;
    pe = 1'b0;
    wst(PGSM_OFF, SD + 40);
    cyc(2);
    `CHK(ser, 1'b0)
    osel = 1'b0;
    pe = 1'b1;
    ac = 1'b1;
    wst(PGSM_ACTIVE, 40);
    hrq = 1'b1;
    wst(PGSM_RESET, 20);
    `CHK(n >= RD, 1'b1)
    cyc(2);
    `CHK(rails_o, exp_rails(PGSM_RESET, rails))
    cyc(40);
    `CHK(st, PGSM_RESET)
    hrq = 1'b0;
    wst(PGSM_ACTIVE, RM + 30);
    pb = 1'b0;
    wst(PGSM_RESET, LP + 20);
    `CHK(n >= LP - 8, 1'b1)
    wst(PGSM_ACTIVE, RM + 30);
    `CHK(n >= RM - 2, 1'b1)
    wst(PGSM_RESET, LP + 20);
    pb = 1'b1;
    wst(PGSM_ACTIVE, RM + 30);
    flt = 1'b1;
    wst(PGSM_OFF, 10);
    pb = 1'b0;
    cyc(20);
    `CHK(st, PGSM_OFF)
    complete_run();
  end
endmodule
